// >>> hw/rfpc_top.sv
// fault latch, re-enable, discharge, power-good and interrupt control with apb registers
// Notes on behaviour
// - fault input falling edge sets error status, force-disable, both outputs high-z
// - clearing force-disable with pin high restarts both after startup delay
// - clearing force-disable with enable pin low restarts nothing
// - force-on plus cleared force-disable starts that regulator without delay
// - with enable high, the non-forced regulator uses its own startup delay
// - each regulator has an independent discharge enable bit
// - inverter discharge switches off once its output reaches zero volts
// - power-good status and interrupt flag per regulator, host readable
// - power-good pin released only when both enabled and both good
// - during the fault state both count disabled, power-good pin low
// - interrupt pin driven low while any unmasked flag is set
// - interrupts come out of reset masked; software unmasks what it wants
// - enable low turns on discharge only after the power-down delay ends
// - up and down delays in 16 steps of 0.2 ms from enable edges
`timescale 1ns/1ps
`default_nettype none
module rfpc_top
    import rfpc_pkg::*;
(
    input wire logic pclk, // apb clock, 10 MHz
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic enable_pin, // enable pin, high to run
    input wire logic fault_input_n, // external fault, low active
    input wire logic inverter_pok_in, // inverter output in regulation
    input wire logic booster_pok_in, // booster output in regulation
    input wire logic inverter_at_zero, // inverter output reached 0 V
    output logic inverter_run, // inverter regulating
    output logic booster_run, // booster regulating
    output logic inverter_discharge_on, // inverter discharge path on
    output logic booster_discharge_on, // booster discharge path on
    output logic power_good_out_o, // power-good pin output value
    output logic power_good_out_oe, // power-good pin drive enable
    output logic interrupt_out_n_o, // interrupt pin output value
    output logic interrupt_out_n_oe // interrupt pin drive enable
);
    // synchronised pin levels
    logic en_s;
    logic fault_n_s;
    logic ipg_s;
    logic bpg_s;
    logic izero_s;
    logic fault_n_d_reg;
    logic fault_fall;
    // register state
    logic [4:0] ctrl_reg;
    logic [15:0] dly_reg;
    logic [2:0] flag_reg;
    logic [2:0] flag_next;
    logic [2:0] mask_reg;
    logic ipg_d_reg;
    logic bpg_d_reg;
    logic [10:0] step_reg;
    logic tick;
    // apb handshake
    logic wr_en;
    logic setup;
    logic addr_ok;
    logic [31:0] rd_val;
    logic both_good;
    logic irq_req;

    // write strobe for one register offset
    function automatic logic reg_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
        return wr && addr == ofs;
    endfunction : reg_hit

    // pin synchronisers
    rfpc_sync #(
        .RST_VAL(1'b0)
    ) u_en (
        .pclk(pclk),
        .presetn(presetn),
        .d(enable_pin),
        .q(en_s)
    );
    rfpc_sync #(
        .RST_VAL(1'b1)
    ) u_fault (
        .pclk(pclk),
        .presetn(presetn),
        .d(fault_input_n),
        .q(fault_n_s)
    );
    rfpc_sync #(
        .RST_VAL(1'b0)
    ) u_ipg (
        .pclk(pclk),
        .presetn(presetn),
        .d(inverter_pok_in),
        .q(ipg_s)
    );
    rfpc_sync #(
        .RST_VAL(1'b0)
    ) u_bpg (
        .pclk(pclk),
        .presetn(presetn),
        .d(booster_pok_in),
        .q(bpg_s)
    );
    rfpc_sync #(
        .RST_VAL(1'b0)
    ) u_izero (
        .pclk(pclk),
        .presetn(presetn),
        .d(inverter_at_zero),
        .q(izero_s)
    );

    // apb decode
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    always_comb begin
        addr_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: rd_val[4:0] = ctrl_reg;
            OFS_DLY: rd_val[15:0] = dly_reg;
            OFS_STAT: begin
                rd_val[ST_ERR] = !fault_n_s;
                rd_val[ST_IPG] = ipg_s;
                rd_val[ST_BPG] = bpg_s;
                rd_val[ST_IEN] = inverter_run;
                rd_val[ST_BEN] = booster_run;
            end
            OFS_INT: rd_val[2:0] = flag_reg;
            OFS_MASK: rd_val[2:0] = mask_reg;
            default: addr_ok = 1'b0;
        endcase
    end

    // zero-wait answer: ready in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // unmapped offsets answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !addr_ok;
        end
    end

    // read data held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_val;
        end else if (!psel) begin
            prdata <= 32'h0000_0000;
        end
    end

    // fault input edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_n_d_reg <= 1'b1;
        end else begin
            fault_n_d_reg <= fault_n_s;
        end
    end
    assign fault_fall = fault_n_d_reg && !fault_n_s;

    // control register; fault edge wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
        end else begin
            if (reg_hit(wr_en, paddr, OFS_CTRL)) begin
                ctrl_reg[CTL_IFON] <= pwdata[CTL_IFON];
                ctrl_reg[CTL_BFON] <= pwdata[CTL_BFON];
                ctrl_reg[CTL_BADE] <= pwdata[CTL_BADE];
                ctrl_reg[CTL_IADE] <= pwdata[CTL_IADE];
                if (fault_n_s) begin
                    ctrl_reg[CTL_FDIS] <= pwdata[CTL_FDIS];
                end
            end
            if (fault_fall) begin
                ctrl_reg[CTL_FDIS] <= 1'b1;
            end
        end
    end

    // delay codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_reg <= DLY_RST;
        end else if (reg_hit(wr_en, paddr, OFS_DLY)) begin
            dly_reg <= pwdata[15:0];
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= MASK_RST;
        end else if (reg_hit(wr_en, paddr, OFS_MASK)) begin
            mask_reg <= pwdata[2:0];
        end
    end

    // previous power-good levels for change detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ipg_d_reg <= 1'b0;
        end else begin
            ipg_d_reg <= ipg_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bpg_d_reg <= 1'b0;
        end else begin
            bpg_d_reg <= bpg_s;
        end
    end

    // sticky flags: write one clears, a new event wins
    always_comb begin
        flag_next = flag_reg;
        if (reg_hit(wr_en, paddr, OFS_INT)) begin
            flag_next = flag_reg & ~pwdata[2:0];
        end
        if (fault_fall) begin
            flag_next[IRQ_ERR] = 1'b1;
        end
        if (ipg_s != ipg_d_reg) begin
            flag_next[IRQ_IPG] = 1'b1;
        end
        if (bpg_s != bpg_d_reg) begin
            flag_next[IRQ_BPG] = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 3'h0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // 0.2 ms step generator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_reg <= 11'h000;
        end else if (step_reg == STEP_LAST) begin
            step_reg <= 11'h000;
        end else begin
            step_reg <= step_reg + 11'h001;
        end
    end
    assign tick = (step_reg == STEP_LAST);

    // sequencers; force-disable gates both, force-on skips delay
    rfpc_seq u_inv_seq (
        .pclk(pclk),
        .presetn(presetn),
        .en_pin(en_s),
        .force_on(ctrl_reg[CTL_IFON]),
        .force_disable(ctrl_reg[CTL_FDIS]),
        .tick(tick),
        .up_code(dly_reg[DLY_IUP+:4]),
        .dn_code(dly_reg[DLY_IDN+:4]),
        .run(inverter_run)
    );
    rfpc_seq u_bst_seq (
        .pclk(pclk),
        .presetn(presetn),
        .en_pin(en_s),
        .force_on(ctrl_reg[CTL_BFON]),
        .force_disable(ctrl_reg[CTL_FDIS]),
        .tick(tick),
        .up_code(dly_reg[DLY_BUP+:4]),
        .dn_code(dly_reg[DLY_BDN+:4]),
        .run(booster_run)
    );

    // inverter discharge; off while running or once at zero volts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inverter_discharge_on <= 1'b0;
        end else begin
            inverter_discharge_on <= !inverter_run && ctrl_reg[CTL_IADE] && !izero_s;
        end
    end

    // booster discharge; off while running, high-z if disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            booster_discharge_on <= 1'b0;
        end else begin
            booster_discharge_on <= !booster_run && ctrl_reg[CTL_BADE];
        end
    end

    // open-drain power-good: released only when both run and are good
    assign both_good = inverter_run && booster_run && ipg_s && bpg_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_good_out_o <= 1'b0;
            power_good_out_oe <= 1'b1;
        end else begin
            power_good_out_o <= 1'b0;
            power_good_out_oe <= !both_good;
        end
    end

    // open-drain interrupt: pulled low while an unmasked flag is set
    assign irq_req = irq_pending(flag_reg, mask_reg);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_out_n_o <= 1'b0;
            interrupt_out_n_oe <= 1'b0;
        end else begin
            interrupt_out_n_o <= 1'b0;
            interrupt_out_n_oe <= irq_req;
        end
    end
endmodule : rfpc_top
`default_nettype wire

// >>> hw/rfpc_pkg.sv
// constants and types shared by the regulator fault and power-good control block
package rfpc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DLY = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_INT = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    // control register fields
    localparam int CTL_FDIS = 0;
    localparam int CTL_IFON = 1;
    localparam int CTL_BFON = 2;
    localparam int CTL_BADE = 3;
    localparam int CTL_IADE = 4;
    localparam logic [4:0] CTRL_RST = 5'h18;
    // delay register fields, 4-bit codes
    localparam int DLY_IDN = 0;
    localparam int DLY_IUP = 4;
    localparam int DLY_BDN = 8;
    localparam int DLY_BUP = 12;
    localparam logic [15:0] DLY_RST = 16'h0000;
    // status register fields
    localparam int ST_ERR = 0;
    localparam int ST_IPG = 1;
    localparam int ST_BPG = 2;
    localparam int ST_IEN = 3;
    localparam int ST_BEN = 4;
    // interrupt flag and mask fields
    localparam int IRQ_ERR = 0;
    localparam int IRQ_IPG = 1;
    localparam int IRQ_BPG = 2;
    localparam logic [2:0] MASK_RST = 3'h7;
    // delay step timing
    localparam int CLK_PERIOD_NS = 100;
    localparam real STEP_MS = 0.2;
    localparam int STEP_CYC = int'(STEP_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam logic [10:0] STEP_LAST = 11'(STEP_CYC - 1);
    typedef enum logic [1:0] {SQ_OFF, SQ_UP, SQ_ON, SQ_DN} rfpc_seq_t;
    // any unmasked flag pending
    function automatic logic irq_pending(input logic [2:0] flags, input logic [2:0] mask);
        irq_pending = |(flags & ~mask);
    endfunction : irq_pending
endpackage : rfpc_pkg

// >>> hw/rfpc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rfpc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic d, // asynchronous input
    output logic q // filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // change accepted once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST_VAL;
        end else if (s2_reg == s3_reg) begin
            q <= s3_reg;
        end
    end
endmodule : rfpc_sync
`default_nettype wire

// >>> hw/rfpc_seq.sv
// per-regulator power-up and power-down sequencer
`timescale 1ns/1ps
`default_nettype none
module rfpc_seq
    import rfpc_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic en_pin, // synchronised enable pin
    input wire logic force_on, // force-on control bit
    input wire logic force_disable, // force-disable control bit
    input wire logic tick, // one pulse per delay step
    input wire logic [3:0] up_code, // startup delay code
    input wire logic [3:0] dn_code, // power-down delay code
    output logic run // regulator enabled
);
    rfpc_seq_t st_reg;
    logic [3:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= SQ_OFF;
            cnt_reg <= 4'h0;
            run <= 1'b0;
        end else if (force_disable) begin
            // fault latch holds the output off
            st_reg <= SQ_OFF;
            run <= 1'b0;
        end else begin
            case (st_reg)
                SQ_OFF: begin
                    if (force_on) begin
                        st_reg <= SQ_ON;
                        run <= 1'b1;
                    end else if (en_pin) begin
                        st_reg <= SQ_UP;
                        cnt_reg <= up_code;
                    end
                end
                SQ_UP: begin
                    if (force_on) begin
                        st_reg <= SQ_ON;
                        run <= 1'b1;
                    end else if (!en_pin) begin
                        st_reg <= SQ_OFF;
                    end else if (tick && cnt_reg == 4'h0) begin
                        st_reg <= SQ_ON;
                        run <= 1'b1;
                    end else if (tick) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                SQ_ON: begin
                    if (!en_pin && !force_on) begin
                        st_reg <= SQ_DN;
                        cnt_reg <= dn_code;
                    end
                end
                SQ_DN: begin
                    if (en_pin || force_on) begin
                        st_reg <= SQ_ON;
                    end else if (tick && cnt_reg == 4'h0) begin
                        st_reg <= SQ_OFF;
                        run <= 1'b0;
                    end else if (tick) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: begin
                    st_reg <= SQ_OFF;
                    run <= 1'b0;
                end
            endcase
        end
    end
endmodule : rfpc_seq
`default_nettype wire

// >>> tb/rfpc_props.sv
// checker for apb, fault, discharge and power-good behaviour of rfpc_top
`timescale 1ns/1ps
`default_nettype none
module rfpc_props (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic fault_input_n, // fault pin
    input wire logic inverter_at_zero, // inverter at 0 V
    input wire logic inverter_run, // inverter on
    input wire logic booster_run, // booster on
    input wire logic inverter_discharge_on, // inverter discharge
    input wire logic booster_discharge_on, // booster discharge
    input wire logic power_good_out_o, // pg value
    input wire logic power_good_out_oe, // pg drive
    input wire logic interrupt_out_n_o // irq value
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_fault_held;
        !fault_input_n [*8];
    endsequence
    sequence s_zero_held;
        inverter_at_zero [*8];
    endsequence
    AST_APB_READY: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    AST_APB_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_PG_DIS: assert property (!(inverter_run && booster_run) |=> power_good_out_oe)
        else $error("pg pin released with a regulator off");
    AST_FAULT: assert property (s_fault_held |-> !inverter_run && !booster_run && power_good_out_oe)
        else $error("regulators on during fault");
    AST_BDIS: assert property (booster_discharge_on |-> !$past(booster_run))
        else $error("booster discharge while running");
    AST_IDIS: assert property (inverter_discharge_on |-> !$past(inverter_run))
        else $error("inverter discharge while running");
    AST_ZERO: assert property (s_zero_held |-> !inverter_discharge_on)
        else $error("inverter discharge on at 0 V");
    AST_PIN_VAL: assert property (!power_good_out_o && !interrupt_out_n_o)
        else $error("open-drain value not low");
endmodule : rfpc_props
bind rfpc_top rfpc_props i_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .fault_input_n,
    .inverter_at_zero, .inverter_run, .booster_run, .inverter_discharge_on, .booster_discharge_on,
    .power_good_out_o, .power_good_out_oe, .interrupt_out_n_o);
`default_nettype wire

// >>> tb/rfpc_reg_model.sv
// behavioural model of the two regulators' analog feedback
`timescale 1ns/1ps
`default_nettype none
module rfpc_reg_model #(
    parameter int POK_DLY = 20,
    parameter int ZERO_DLY = 30
) (
    input wire logic pclk, // clock
    input wire logic inverter_run, // inverter on
    input wire logic booster_run, // booster on
    input wire logic inverter_discharge_on, // inverter discharge
    output logic inverter_pok_in, // inverter good
    output logic booster_pok_in, // booster good
    output logic inverter_at_zero // inverter at 0 V
);
    int ci = 0;
    int cb = 0;
    int cz = 0;
    always @(posedge pclk) begin
        ci <= inverter_run ? ci + 1 : 0;
        cb <= booster_run ? cb + 1 : 0;
        cz <= inverter_run ? 0 : (inverter_discharge_on ? cz + 1 : cz);
    end
    // good only after a ramp, lost at once when switched off
    assign inverter_pok_in = inverter_run && ci >= POK_DLY;
    assign booster_pok_in = booster_run && cb >= POK_DLY;
    assign inverter_at_zero = cz >= ZERO_DLY;
endmodule : rfpc_reg_model
`default_nettype wire

// >>> tb/regulator_fault_pok_control_tb.sv
// testbench for rfpc_top
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_pok_control_tb;
    import rfpc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic enable_pin = 0, fault_input_n = 1;
    logic [31:0] prdata;
    logic pready, pslverr, inverter_pok_in, booster_pok_in, inverter_at_zero, inverter_run, booster_run;
    logic inverter_discharge_on, booster_discharge_on, power_good_out_o, power_good_out_oe;
    logic interrupt_out_n_o, interrupt_out_n_oe;
    int error_cnt = 0, n_checks = 0, ti, tb;
    logic [32:0] expq[$];
    logic [3:0] ui, bi;
    rfpc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .enable_pin, .fault_input_n, .inverter_pok_in, .booster_pok_in, .inverter_at_zero, .inverter_run,
        .booster_run, .inverter_discharge_on, .booster_discharge_on, .power_good_out_o, .power_good_out_oe,
        .interrupt_out_n_o, .interrupt_out_n_oe);
    rfpc_reg_model i_model (.pclk, .inverter_run, .booster_run, .inverter_discharge_on, .inverter_pok_in,
        .booster_pok_in, .inverter_at_zero);
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr
    // cycles from now until each regulator starts
    task automatic meas;
        int c;
        c = 0;
        ti = 0;
        tb = 0;
        while ((ti == 0 || tb == 0) && c < 9000) begin
            @(posedge pclk);
            c++;
            if (ti == 0 && inverter_run === 1'b1) ti = c;
            if (tb == 0 && booster_run === 1'b1) tb = c;
        end
    endtask : meas
    function automatic logic win(input int t, input logic [3:0] k);
        return t > k * STEP_CYC && t <= (k + 1) * STEP_CYC + 10;
    endfunction : win
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk("apb_read", expq.pop_front(), {pslverr, prdata});
        end
    end
    initial begin
        wt(60000);
        error_cnt++;
        end_sim();
    end
    initial begin
        wt(12);
        presetn <= 1'b1;
        void'($urandom(32'h7c13));
        ui = 4'($urandom % 2);
        bi = 4'($urandom % 2);
        wt(3);
        chk("ibb_dis", 1, inverter_discharge_on);
        chk("bst_dis", 1, booster_discharge_on);
        rd(OFS_CTRL, 33'h18);
        rd(OFS_DLY, 33'h0);
        rd(OFS_STAT, 33'h0);
        rd(OFS_INT, 33'h0);
        rd(OFS_MASK, 33'h7);
        rd(8'h14, 33'h100000000);
        wr(OFS_DLY, {16'h0, bi, 4'h0, ui, 4'h0});
        enable_pin <= 1'b1;
        meas();
        chk("ibb_up", 1, win(ti, ui));
        chk("bst_up", 1, win(tb, bi));
        wt(40);
        chk("pok_pin", 0, power_good_out_oe);
        chk("irq_mask", 0, interrupt_out_n_oe);
        wr(OFS_MASK, 32'h0);
        wt(2);
        chk("irq_pin", 1, interrupt_out_n_oe);
        rd(OFS_STAT, 33'h1e);
        rd(OFS_INT, 33'h6);
        wr(OFS_INT, 32'h6);
        rd(OFS_INT, 33'h0);
        chk("irq_clr", 0, interrupt_out_n_oe);
        fault_input_n <= 1'b0;
        wt(60);
        chk("ibb_run", 0, inverter_run);
        chk("bst_run", 0, booster_run);
        chk("pok_fault", 1, power_good_out_oe);
        chk("ibb_zero", 0, inverter_discharge_on);
        chk("bst_ade", 1, booster_discharge_on);
        rd(OFS_STAT, 33'h1);
        rd(OFS_CTRL, 33'h19);
        wr(OFS_CTRL, 32'h18);
        rd(OFS_CTRL, 33'h19);
        rd(OFS_INT, 33'h7);
        wr(OFS_INT, 32'h7);
        fault_input_n <= 1'b1;
        wt(10);
        rd(OFS_STAT, 33'h0);
        rd(OFS_CTRL, 33'h19);
        wr(OFS_CTRL, 32'h1a);
        meas();
        chk("ibb_force", 1, ti > 0 && ti <= 3);
        chk("bst_other", 1, win(tb, bi));
        fault_input_n <= 1'b0;
        wt(20);
        enable_pin <= 1'b0;
        fault_input_n <= 1'b1;
        wt(10);
        wr(OFS_CTRL, 32'h10);
        wt(4500);
        chk("ibb_off", 0, inverter_run);
        chk("bst_off", 0, booster_run);
        chk("bst_noade", 0, booster_discharge_on);
        end_sim();
    end
endmodule : regulator_fault_pok_control_tb
`default_nettype wire
